// ===== rtl/tgx_timer_gate.v
// Two timer/counters with pin gating, count pins and external interrupts.
`timescale 1ns/10ps
`include "tgx_defs.vh"

module tgx_timer_gate #(
    parameter TICK_DIV = 12
) (
    // Clock and reset.
    input  wire                  clock,
    input  wire                  nrst,
    // External pins.
    input  wire                  ext_irq_a_pin,
    input  wire                  ext_irq_b_pin,
    input  wire                  count_in_a_pin,
    input  wire                  count_in_b_pin,
    // Register port.
    input  wire [`TGX_ADDR_W-1:0] addr,
    input  wire [`TGX_DATA_W-1:0] wr_data,
    input  wire                  wr_en,
    input  wire                  rd_en,
    output reg  [`TGX_DATA_W-1:0] rd_data,
    // Interrupt.
    output reg                   irq
);

    // ************************************************************
    // Helpers
    // ************************************************************

    // Address match used by every strobe decode.
    function hit;
        input [`TGX_ADDR_W-1:0] a;
        input [`TGX_ADDR_W-1:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // ************************************************************
    // Declarations
    // ************************************************************

    // Register state.
    reg  [`TGX_DATA_W-1:0] ctrl_r;
    reg  [`TGX_DATA_W-1:0] mode_r;
    reg  [`TGX_DATA_W-1:0] status_r;
    reg  [`TGX_DATA_W-1:0] status_nxt;
    reg  [`TGX_DATA_W-1:0] mask_r;
    reg  [`TGX_DATA_W-1:0] rd_nxt;
    reg  [7:0]             div_r;
    reg                    tick_r;

    // Synchronised pin levels and fall pulses.
    wire                   irq_a_lvl;
    wire                   irq_a_fall;
    wire                   irq_b_lvl;
    wire                   irq_b_fall;
    wire                   cnt_a_lvl;
    wire                   cnt_a_fall;
    wire                   cnt_b_lvl;
    wire                   cnt_b_fall;

    // Channel results.
    wire [`TGX_CNT_W-1:0]  count_a;
    wire [`TGX_CNT_W-1:0]  count_b;
    wire                   ovf_a;
    wire                   ovf_b;

    // Decoded fields and events.
    wire                   trigger_type_a;
    wire                   trigger_type_b;
    wire                   gate_select_a;
    wire                   gate_select_b;
    wire                   irq_pending_a_set;
    wire                   irq_pending_b_set;
    reg  [`TGX_DATA_W-1:0] events;
    wire [7:0]             div_last;

    // Decoded strobes and next interrupt.
    wire                   wr_ctrl;
    wire                   wr_mode;
    wire                   wr_mask;
    wire                   wr_cnt_a_lo;
    wire                   wr_cnt_a_hi;
    wire                   wr_cnt_b_lo;
    wire                   wr_cnt_b_hi;
    wire                   rd_status;
    wire                   irq_nxt;

    assign trigger_type_a = ctrl_r[`TGX_CTRL_TRIG_A];
    assign trigger_type_b = ctrl_r[`TGX_CTRL_TRIG_B];
    assign gate_select_a  = mode_r[`TGX_MODE_GATE_A];
    assign gate_select_b  = mode_r[`TGX_MODE_GATE_B];
    assign div_last       = TICK_DIV[7:0] - 8'h01;

    // ************************************************************
    // Register strobes
    // ************************************************************

    // Each write is decoded once here, so a register write and the count
    // load that it causes can never disagree about the address.
    assign wr_ctrl     = wr_en & hit(addr, `TGX_OFF_CTRL);
    assign wr_mode     = wr_en & hit(addr, `TGX_OFF_MODE);
    assign wr_mask     = wr_en & hit(addr, `TGX_OFF_MASK);
    assign wr_cnt_a_lo = wr_en & hit(addr, `TGX_OFF_CNT_A_LO);
    assign wr_cnt_a_hi = wr_en & hit(addr, `TGX_OFF_CNT_A_HI);
    assign wr_cnt_b_lo = wr_en & hit(addr, `TGX_OFF_CNT_B_LO);
    assign wr_cnt_b_hi = wr_en & hit(addr, `TGX_OFF_CNT_B_HI);
    assign rd_status   = rd_en & hit(addr, `TGX_OFF_STATUS);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************

    tgx_edge_sync u_sync_irq_a (
        .clock (clock),
        .nrst  (nrst),
        .pin   (ext_irq_a_pin),
        .level (irq_a_lvl),
        .fall  (irq_a_fall)
    );

    tgx_edge_sync u_sync_irq_b (
        .clock (clock),
        .nrst  (nrst),
        .pin   (ext_irq_b_pin),
        .level (irq_b_lvl),
        .fall  (irq_b_fall)
    );

    tgx_edge_sync u_sync_cnt_a (
        .clock (clock),
        .nrst  (nrst),
        .pin   (count_in_a_pin),
        .level (cnt_a_lvl),
        .fall  (cnt_a_fall)
    );

    tgx_edge_sync u_sync_cnt_b (
        .clock (clock),
        .nrst  (nrst),
        .pin   (count_in_b_pin),
        .level (cnt_b_lvl),
        .fall  (cnt_b_fall)
    );

    // ************************************************************
    // Timer prescaler
    // ************************************************************

    // In timer mode both channels share one tick, so a free run of the
    // prescaler keeps them in step with each other.
    // TICK_DIV must lie between 1 and 255; the divider is only eight bits
    // wide and a larger value would wrap silently.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            div_r  <= `TGX_RST_DIV;
            tick_r <= 1'b0;
        end else begin
            if (div_r >= div_last) begin
                div_r  <= `TGX_RST_DIV;
                tick_r <= 1'b1;
            end else begin
                div_r  <= div_r + 8'h01;
                tick_r <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Timer channels
    // ************************************************************

    // The gate follows the synchronised pin, two clocks late; a pin pulse
    // shorter than a clock may be missed, which buys freedom from metastability.
    // pin A gates timer A
    // count pin A falls step timer A
    tgx_timer_chan u_timer_a (
        .clock      (clock),
        .nrst       (nrst),
        .run_bit    (ctrl_r[`TGX_CTRL_RUN_A]),
        .gate_sel   (gate_select_a),
        .gate_lvl   (irq_a_lvl),
        .cnt_mode   (mode_r[`TGX_MODE_CNT_A]),
        .tick       (tick_r),
        .count_fall (cnt_a_fall),
        .load_lo    (wr_cnt_a_lo),
        .load_hi    (wr_cnt_a_hi),
        .wr_byte    (wr_data),
        .count      (count_a),
        .ovf        (ovf_a)
    );

    // count pin B falls step timer B
    tgx_timer_chan u_timer_b (
        .clock      (clock),
        .nrst       (nrst),
        .run_bit    (ctrl_r[`TGX_CTRL_RUN_B]),
        .gate_sel   (gate_select_b),
        .gate_lvl   (irq_b_lvl),
        .cnt_mode   (mode_r[`TGX_MODE_CNT_B]),
        .tick       (tick_r),
        .count_fall (cnt_b_fall),
        .load_lo    (wr_cnt_b_lo),
        .load_hi    (wr_cnt_b_hi),
        .wr_byte    (wr_data),
        .count      (count_b),
        .ovf        (ovf_b)
    );

    // ************************************************************
    // External interrupt detection
    // ************************************************************

    assign irq_pending_a_set = trigger_type_a ? irq_a_fall : ~irq_a_lvl;

    assign irq_pending_b_set = trigger_type_b ? irq_b_fall : ~irq_b_lvl;

    // Event bits land at the status field positions; the rest stay low.
    always @* begin
        events                 = `TGX_RST_BYTE;
        events[`TGX_ST_PEND_A] = irq_pending_a_set;
        events[`TGX_ST_PEND_B] = irq_pending_b_set;
        events[`TGX_ST_OVF_A]  = ovf_a;
        events[`TGX_ST_OVF_B]  = ovf_b;
    end

    // A read clears the status, but an event of the same cycle is kept.
    // In level mode the pending flag therefore stays set while the pin is
    // held low, even across reads.
    always @* begin
        status_nxt = status_r;
        if (rd_status) begin
            status_nxt = `TGX_RST_BYTE;
        end
        status_nxt = status_nxt | events;
    end

    // The interrupt follows the next status rather than the stored one, so
    // it rises on the edge that sets a flag and falls on the edge at which
    // a read clears the last unmasked one.
    assign irq_nxt = |(status_nxt & mask_r);

    // ************************************************************
    // Register writes
    // ************************************************************

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl_r   <= `TGX_RST_BYTE;
            mode_r   <= `TGX_RST_BYTE;
            mask_r   <= `TGX_RST_BYTE;
            status_r <= `TGX_RST_BYTE;
        end else begin
            status_r <= status_nxt;
            if (wr_ctrl) begin
                ctrl_r <= {4'h0, wr_data[3:0]};
            end
            if (wr_mode) begin
                mode_r <= {4'h0, wr_data[3:0]};
            end
            if (wr_mask) begin
                mask_r <= {4'h0, wr_data[3:0]};
            end
        end
    end

    // ************************************************************
    // Register reads
    // ************************************************************

    // Unmapped offsets read as zero; the status read returns the value
    // before the clear so that no event is lost to software.
    // Counts are read a byte at a time with no snapshot; a running channel
    // can carry between the low and high reads, so software should stop it
    // or read twice.
    always @* begin
        rd_nxt = `TGX_RST_BYTE;
        case (addr)
            `TGX_OFF_CTRL: begin
                rd_nxt = ctrl_r;
            end
            `TGX_OFF_MODE: begin
                rd_nxt = mode_r;
            end
            `TGX_OFF_STATUS: begin
                rd_nxt = status_r;
            end
            `TGX_OFF_MASK: begin
                rd_nxt = mask_r;
            end
            `TGX_OFF_CNT_A_LO: begin
                rd_nxt = count_a[7:0];
            end
            `TGX_OFF_CNT_A_HI: begin
                rd_nxt = count_a[15:8];
            end
            `TGX_OFF_CNT_B_LO: begin
                rd_nxt = count_b[7:0];
            end
            `TGX_OFF_CNT_B_HI: begin
                rd_nxt = count_b[15:8];
            end
            `TGX_OFF_PINS: begin
                // Synchronised levels, two clocks behind the pads.
                rd_nxt = {4'h0, cnt_b_lvl, cnt_a_lvl, irq_b_lvl, irq_a_lvl};
            end
            default: begin
                rd_nxt = `TGX_RST_BYTE;
            end
        endcase
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    // Read data holds for one cycle only and is zero otherwise.
    // Zero between reads lets several slaves share one return path by an OR.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_data <= `TGX_RST_BYTE;
            irq     <= 1'b0;
        end else begin
            rd_data <= rd_en ? rd_nxt : `TGX_RST_BYTE;
            irq     <= irq_nxt;
        end
    end

endmodule // tgx_timer_gate

// ===== rtl/tgx_defs.vh
// Constants for the timer gate and external interrupt input block.
`ifndef TGX_DEFS_VH
`define TGX_DEFS_VH

// Register bus widths and counter width.
`define TGX_ADDR_W       4
`define TGX_DATA_W       8
`define TGX_CNT_W        16

// Register offsets.
`define TGX_OFF_CTRL     4'h0
`define TGX_OFF_MODE     4'h1
`define TGX_OFF_STATUS   4'h2
`define TGX_OFF_MASK     4'h3
`define TGX_OFF_CNT_A_LO 4'h4
`define TGX_OFF_CNT_A_HI 4'h5
`define TGX_OFF_CNT_B_LO 4'h6
`define TGX_OFF_CNT_B_HI 4'h7
`define TGX_OFF_PINS     4'h8

// Control register fields.
`define TGX_CTRL_TRIG_A  0
`define TGX_CTRL_TRIG_B  1
`define TGX_CTRL_RUN_A   2
`define TGX_CTRL_RUN_B   3

// Mode register fields.
`define TGX_MODE_GATE_A  0
`define TGX_MODE_GATE_B  1
`define TGX_MODE_CNT_A   2
`define TGX_MODE_CNT_B   3

// Status and mask register fields.
`define TGX_ST_PEND_A    0
`define TGX_ST_PEND_B    1
`define TGX_ST_OVF_A     2
`define TGX_ST_OVF_B     3

// Reset values.
`define TGX_RST_BYTE     8'h00
`define TGX_RST_CNT      16'h0000
`define TGX_RST_PIN      1'b1
`define TGX_RST_DIV      8'h00

`endif

// ===== rtl/tgx_edge_sync.v
// Two-stage pin synchroniser with a falling edge detector.
`timescale 1ns/10ps
`include "tgx_defs.vh"

module tgx_edge_sync (
    // Clock and reset.
    input  wire clock,
    input  wire nrst,
    // Asynchronous pin.
    input  wire pin,
    // Synchronised level and one-cycle falling edge pulse.
    output reg  level,
    output reg  fall
);

    reg meta_r;
    reg prev_r;

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta_r <= `TGX_RST_PIN;
            level  <= `TGX_RST_PIN;
            prev_r <= `TGX_RST_PIN;
            fall   <= 1'b0;
        end else begin
            meta_r <= pin;
            level  <= meta_r;
            prev_r <= level;
            fall   <= prev_r & ~level;
        end
    end

endmodule // tgx_edge_sync

// ===== rtl/tgx_timer_chan.v
// One 16-bit timer/counter channel with gate and count-pin stepping.
`timescale 1ns/10ps
`include "tgx_defs.vh"

module tgx_timer_chan (
    // Clock and reset.
    input  wire                  clock,
    input  wire                  nrst,
    // Run control.
    input  wire                  run_bit,
    input  wire                  gate_sel,
    input  wire                  gate_lvl,
    input  wire                  cnt_mode,
    // Step sources.
    input  wire                  tick,
    input  wire                  count_fall,
    // Software load.
    input  wire                  load_lo,
    input  wire                  load_hi,
    input  wire [7:0]            wr_byte,
    // Results.
    output reg  [`TGX_CNT_W-1:0] count,
    output reg                   ovf
);

    wire enable;
    wire step;

    // Gated run control.
    assign enable = run_bit & (~gate_sel | gate_lvl);
    assign step   = enable & (cnt_mode ? count_fall : tick);

    // A software load wins over a step in the same cycle, so that a loaded
    // value is never skipped by one.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count <= `TGX_RST_CNT;
            ovf   <= 1'b0;
        end else begin
            ovf <= 1'b0;
            if (load_lo) begin
                count[7:0] <= wr_byte;
            end else if (load_hi) begin
                count[15:8] <= wr_byte;
            end else if (step) begin
                count <= count + 16'h0001;
                ovf   <= &count;
            end
        end
    end

endmodule // tgx_timer_chan

// ===== test/tgx_timer_gate_chk.sv
// Port-level assertions for the timer gate and external interrupt block.
`timescale 1ns/10ps
`include "tgx_defs.vh"

module tgx_timer_gate_chk #(
    parameter TICK_DIV = 12
) (
    // Clock and reset.
    input wire                    clock,
    input wire                    nrst,
    // External pins.
    input wire                    ext_irq_a_pin,
    input wire                    ext_irq_b_pin,
    input wire                    count_in_a_pin,
    input wire                    count_in_b_pin,
    // Register port.
    input wire [`TGX_ADDR_W-1:0] addr,
    input wire [`TGX_DATA_W-1:0] wr_data,
    input wire                    wr_en,
    input wire                    rd_en,
    input wire [`TGX_DATA_W-1:0] rd_data,
    // Interrupt.
    input wire                    irq
);
    // Shadows of control and mask; wq waits out the write-to-effect delay.
    reg  [3:0] ctrl_s;
    reg  [3:0] mask_s;
    reg  [2:0] wq;
    reg  [2:0] up;
    reg  [2:0] lo_a;
    reg  [2:0] lo_b;
    wire [3:0] pv = {count_in_b_pin, count_in_a_pin, ext_irq_b_pin, ext_irq_a_pin};
    wire       cw = wr_en && (addr == `TGX_OFF_CTRL || addr == `TGX_OFF_MASK);

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl_s <= 4'h0;
            mask_s <= 4'h0;
            wq     <= 3'h0;
            up     <= 3'h0;
            lo_a   <= 3'h0;
            lo_b   <= 3'h0;
        end else begin
            if (wr_en && addr == `TGX_OFF_CTRL) ctrl_s <= wr_data[3:0];
            if (wr_en && addr == `TGX_OFF_MASK) mask_s <= wr_data[3:0];
            wq   <= cw ? 3'h0 : (wq == 3'h7 ? wq : wq + 3'h1);
            up   <= (up == 3'h7) ? up : up + 3'h1;
            lo_a <= ext_irq_a_pin ? 3'h0 : (lo_a == 3'h7 ? lo_a : lo_a + 3'h1);
            lo_b <= ext_irq_b_pin ? 3'h0 : (lo_b == 3'h7 ? lo_b : lo_b + 3'h1);
        end
    end

    a_rd_idle_zero: assert property (@(posedge clock) disable iff (!nrst)
        !rd_en |=> rd_data == 8'h00) else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (@(posedge clock) disable iff (!nrst)
        rd_en && addr > 4'h8 |=> rd_data == 8'h00) else $error("unmapped read not zero");
    a_pins_level: assert property (@(posedge clock) disable iff (!nrst)
        rd_en && addr == `TGX_OFF_PINS && up == 3'h7 && $stable(pv) && pv == $past(pv, 2)
        |=> rd_data[3:0] == $past(pv)) else $error("pin levels read wrong");
    a_edge_irq_a: assert property (@(posedge clock) disable iff (!nrst)
        $fell(ext_irq_a_pin) && up == 3'h7 && wq > 3'h1 && ctrl_s[0] && mask_s[0]
        |-> ##[1:6] irq) else $error("falling edge on pin A gave no interrupt");
    a_edge_irq_b: assert property (@(posedge clock) disable iff (!nrst)
        $fell(ext_irq_b_pin) && up == 3'h7 && wq > 3'h1 && ctrl_s[1] && mask_s[1]
        |-> ##[1:6] irq) else $error("falling edge on pin B gave no interrupt");
    a_level_irq_a: assert property (@(posedge clock) disable iff (!nrst)
        lo_a > 3'h4 && wq > 3'h1 && !ctrl_s[0] && mask_s[0] |-> irq)
        else $error("low level on pin A gave no interrupt");
    a_level_irq_b: assert property (@(posedge clock) disable iff (!nrst)
        lo_b > 3'h4 && wq > 3'h1 && !ctrl_s[1] && mask_s[1] |-> irq)
        else $error("low level on pin B gave no interrupt");
    a_masked_quiet: assert property (@(posedge clock) disable iff (!nrst)
        wq > 3'h1 && mask_s == 4'h0 |-> !irq) else $error("interrupt with all masked");
endmodule // tgx_timer_gate_chk

bind tgx_timer_gate tgx_timer_gate_chk #(.TICK_DIV(TICK_DIV)) i_chk (.clock(clock),
    .nrst(nrst), .ext_irq_a_pin(ext_irq_a_pin), .ext_irq_b_pin(ext_irq_b_pin),
    .count_in_a_pin(count_in_a_pin), .count_in_b_pin(count_in_b_pin), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq));

// ===== test/tgx_pin_model.sv
// Model of the external interrupt sources and count pulse sources.
`timescale 1ns/10ps

module tgx_pin_model (
    // Clock.
    input  wire       clock,
    // Pins: count B, count A, interrupt B, interrupt A.
    output reg  [3:0] pins
);
    // Idle high, as the port pull-ups hold the lines.
    initial pins = 4'hF;

    task set_pin(input int idx, input logic lvl);
        @(posedge clock);
        pins[idx] <= lvl;
    endtask

    // A wide w suits a slow source; w of 0, one clock low and one high, is the fastest the block resolves.
    task pulse(input int idx, input int n, input int w);
        repeat (n) begin
            set_pin(idx, 1'b0);
            repeat (w) @(posedge clock);
            set_pin(idx, 1'b1);
            repeat (w) @(posedge clock);
        end
    endtask
endmodule // tgx_pin_model

// ===== test/tgx_timer_gate_tb.sv
// Self-checking bench for the timer gate and external interrupt block.
`timescale 1ns/10ps
`include "tgx_defs.vh"
`define TGX_CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tgx_timer_gate_tb;
    reg        clock = 1'b0;
    reg        nrst = 1'b0;
    reg  [3:0] addr = 4'h0;
    reg  [7:0] wr_data = 8'h00;
    reg        wr_en = 1'b0;
    reg        rd_en = 1'b0;
    wire [7:0] rd_data;
    wire       irq;
    wire [3:0] pins;
    int        failures = 0;
    int        comparisons = 0;
    int        cycles = 0;
    logic [7:0] d;

    always #5 clock = ~clock;

    tgx_pin_model i_src (.clock(clock), .pins(pins));

    // A short prescale keeps timer mode quick; counter mode ignores it.
    tgx_timer_gate #(.TICK_DIV(2)) i_dut (.clock(clock), .nrst(nrst),
        .ext_irq_a_pin(pins[0]), .ext_irq_b_pin(pins[1]), .count_in_a_pin(pins[2]),
        .count_in_b_pin(pins[3]), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .irq(irq));

    task report_and_stop;
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            report_and_stop;
        end
    end

    task idle(input int n);
        repeat (n) @(posedge clock);
    endtask

    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock);
        wr_en   <= 1'b1;
        addr    <= a;
        wr_data <= v;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask

    task rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clock);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        v = rd_data;
    endtask

    task rd_chk(input logic [3:0] a, input logic [7:0] e);
        rd(a, d);
        `TGX_CHK(d, e)
    endtask

    initial begin
        idle(10);
        nrst <= 1'b1;
        idle(4);
        // Reset values, pin levels and an ignored write to an unmapped place.
        wr(4'hC, 8'h5A);
        for (int a = 0; a < 16; a++) rd_chk(4'(a), (a == 8) ? 8'h0F : 8'h00);
        // Counter mode on both channels, fast and slow pulses, then overflow.
        wr(`TGX_OFF_MODE, 8'h0C);
        wr(`TGX_OFF_CTRL, 8'h0C);
        i_src.pulse(2, 5, 1);
        i_src.pulse(3, 3, 4);
        idle(4);
        rd_chk(`TGX_OFF_CNT_A_LO, 8'h05);
        rd_chk(`TGX_OFF_CNT_B_LO, 8'h03);
        wr(`TGX_OFF_CNT_A_HI, 8'hFF);
        wr(`TGX_OFF_CNT_A_LO, 8'hFF);
        i_src.pulse(2, 1, 2);
        idle(4);
        rd_chk(`TGX_OFF_CNT_A_LO, 8'h00);
        rd_chk(`TGX_OFF_CNT_A_HI, 8'h00);
        rd_chk(`TGX_OFF_STATUS, 8'h04);
        // Gating: steps while the interrupt pin is low must be lost.
        for (int ch = 0; ch < 2; ch++) begin
            wr(`TGX_OFF_MODE, 8'h05 << ch);
            wr(`TGX_OFF_CTRL, 8'h0F);
            wr(`TGX_OFF_CNT_A_LO + 4'(2 * ch), 8'h00);
            i_src.set_pin(ch, 1'b0);
            i_src.pulse(2 + ch, 2, 2);
            rd_chk(`TGX_OFF_PINS, 8'h0F & ~(8'h01 << ch));
            i_src.set_pin(ch, 1'b1);
            idle(2);
            i_src.pulse(2 + ch, 3, 2);
            idle(4);
            rd_chk(`TGX_OFF_CNT_A_LO + 4'(2 * ch), 8'h03);
        end
        // Timer mode through an open gate: eight clocks at a prescale of two give four steps.
        wr(`TGX_OFF_CTRL, 8'h00);
        wr(`TGX_OFF_MODE, 8'h01);
        wr(`TGX_OFF_CNT_A_LO, 8'h00);
        wr(`TGX_OFF_CTRL, 8'h04);
        idle(6);
        wr(`TGX_OFF_CTRL, 8'h00);
        rd_chk(`TGX_OFF_CNT_A_LO, 8'h04);
        // Edge and level triggering on each interrupt pin.
        wr(`TGX_OFF_MASK, 8'h03);
        for (int ch = 0; ch < 2; ch++) begin
            wr(`TGX_OFF_CTRL, 8'h03);
            rd(`TGX_OFF_STATUS, d);
            i_src.set_pin(ch, 1'b0);
            idle(8);
            `TGX_CHK(irq, 1'b1)
            rd_chk(`TGX_OFF_STATUS, 8'h01 << ch);
            rd_chk(`TGX_OFF_STATUS, 8'h00);
            idle(2);
            `TGX_CHK(irq, 1'b0)
            wr(`TGX_OFF_CTRL, 8'h00);
            idle(4);
            rd_chk(`TGX_OFF_STATUS, 8'h01 << ch);
            rd_chk(`TGX_OFF_STATUS, 8'h01 << ch);
            `TGX_CHK(irq, 1'b1)
            i_src.set_pin(ch, 1'b1);
            idle(4);
            rd(`TGX_OFF_STATUS, d);
            rd_chk(`TGX_OFF_STATUS, 8'h00);
        end
        // A masked event is still recorded but raises no interrupt.
        wr(`TGX_OFF_CTRL, 8'h03);
        wr(`TGX_OFF_MASK, 8'h00);
        i_src.pulse(0, 1, 2);
        idle(6);
        `TGX_CHK(irq, 1'b0)
        rd_chk(`TGX_OFF_STATUS, 8'h01);
        report_and_stop;
    end
endmodule // tgx_timer_gate_tb
